// file: src/rx_status_pkg.sv
// Purpose: Shared constants and carrier types for the receive status register bank.
// Assumes: Registers sit at word index * 4 on a 32-bit AHB-Lite bus.
// Notes: Event carriers come from logic on the same clock as the register bank.
package rx_status_pkg;

  // Register word indices; the byte address is four times the index.
  localparam logic [7:0] IDX_ERROR_WAKEUP_IRQ = 8'h19;
  localparam logic [7:0] IDX_FIFO_BYTE_COUNT = 8'h1A;
  localparam logic [7:0] IDX_FIFO_LAST_BYTE_STATUS = 8'h1B;
  localparam logic [7:0] IDX_COLLISION_POSITION = 8'h1C;
  localparam logic [7:0] IDX_WAKEUP_MASK = 8'h30;
  localparam logic [7:0] IDX_STATUS_CONTROL = 8'h31;
  localparam logic [7:0] IDX_WAKEUP_DELTAS = 8'h32;
  localparam logic [7:0] IDX_COMMAND = 8'h33;

  // Error and wake-up register bits.
  localparam int ERR_CRC_BIT = 7;
  localparam int ERR_PARITY_BIT = 6;
  localparam int ERR_SOFT_FRAMING_BIT = 5;
  localparam int ERR_HARD_FRAMING_BIT = 4;
  localparam int ERR_WAKEUP_TIMER_BIT = 3;
  localparam int ERR_WAKE_AMPLITUDE_BIT = 2;
  localparam int ERR_WAKE_PHASE_BIT = 1;
  localparam int ERR_WAKE_CAPACITANCE_BIT = 0;

  // FIFO last-byte status bits.
  localparam int FIFO_UNDERFLOW_BIT = 6;
  localparam int FIFO_OVERFLOW_BIT = 5;
  localparam int FIFO_INCOMPLETE_BIT = 4;
  localparam int FIFO_LAST_BITS_LSB = 1;
  localparam int FIFO_MISSING_PARITY_BIT = 0;

  // Collision position fields.
  localparam int COLL_BYTES_LSB = 4;
  localparam int COLL_BITS_LSB = 1;
  localparam int COLL_PARITY_BIT = 0;

  // Control and command bits.
  localparam int CTRL_WT_EVERY_TIMEOUT_BIT = 0;
  localparam int CMD_SET_DEFAULT_BIT = 0;
  localparam int CMD_CLEAR_BIT = 1;

  localparam logic [7:0] REG8_RESET = 8'h00;
  localparam logic [6:0] FIFO_MAX_BYTES = 7'h60;

  typedef struct packed {
    logic crc_error;
    logic parity_error;
    logic soft_framing;
    logic hard_framing;
    logic wakeup_timeout;
  } rx_err_events_s;

  // Channel order matches the wake-up bit positions: 0 capacitance, 1 phase, 2 amplitude.
  typedef struct packed {
    logic [2:0] valid;
    logic [2:0][7:0] value;
    logic [2:0][7:0] reference;
  } wake_meas_s;

  typedef struct packed {
    logic [6:0] count;
    logic host_read;
    logic overflow;
    logic last_update;
    logic last_incomplete;
    logic [2:0] last_bits;
    logic missing_parity;
  } fifo_state_s;

  typedef struct packed {
    logic event_hit;
    logic anticoll_frame;
    logic frame_start;
    logic [3:0] full_bytes;
    logic [2:0] bits;
    logic on_parity;
  } collision_s;

endpackage

// file: src/rx_status_regs.sv
// Purpose: Receive error, wake-up, FIFO status and collision registers on AHB-Lite.
// Assumes: Event inputs are driven by logic on SYS_CLK_I; single word transfers only.
// Notes: Zero wait states; every response is OKAY; unmapped reads return zero.
//
// Summary of operation
// - Soft framing error sets error bit 5.
// - Hard framing bit 4; CRC 7, parity 6.
// - Wake-up timeout sets bit 3 if option selected.
// - Phase beyond delta sets bit 1.
// - Reset and set-default zero error register.
// - Reading error register clears it.
// - FIFO count is 7 bits, 0 to 96.
// - Underflow bit 6 on overread; overflow bit 5.
// - Incomplete last byte sets bit 4.
// - Valid bit count of last byte, bits 3:1.
// - Missing parity sets bit 0, a framing error.
// - Empty FIFO: count zero, incomplete bit and bits 1:0 of the bit count cleared.
// - Reset, set-default, clear zero FIFO and collision.
// - Full bytes before collision in bits 7:4.
// - Bits before collision in bits 3:1.
// - Only anticollision-frame collisions update the register.
// - Parity collision bit 0, first collision only.
// - Unmasked error flag drives summary bit until read.
// - Mask bit per flag suppresses its interrupt.
`timescale 1ns/1ps
`default_nettype none

module rx_status_regs #(
  parameter int FIFO_DEPTH = 96,
  parameter int MEAS_W = 8
) (
  input wire logic SYS_CLK_I,
  input wire logic RST_N_I,
  input wire logic HSEL_I,
  input wire logic [31:0] HADDR_I,
  input wire logic [1:0] HTRANS_I,
  input wire logic HWRITE_I,
  input wire logic [2:0] HSIZE_I,
  input wire logic [31:0] HWDATA_I,
  input wire logic HREADY_I,
  output logic [31:0] HRDATA_O,
  output logic HREADYOUT_O,
  output logic HRESP_O,
  input wire rx_status_pkg::rx_err_events_s RX_ERR_EVENTS_I,
  input wire rx_status_pkg::wake_meas_s WAKE_MEAS_I,
  input wire rx_status_pkg::fifo_state_s FIFO_STATE_I,
  input wire rx_status_pkg::collision_s COLLISION_I,
  output logic ERR_SUMMARY_O
);

  if (FIFO_DEPTH < 1 || FIFO_DEPTH > int'(rx_status_pkg::FIFO_MAX_BYTES)) begin : g_bad_depth
    $error("FIFO_DEPTH must lie between 1 and 96.");
  end
  if (MEAS_W != 8) begin : g_bad_meas
    $error("MEAS_W must be 8 to match the packed measurement carrier.");
  end

  localparam logic [6:0] DEPTH_MAX = 7'(FIFO_DEPTH);

  // Bus decode. HSIZE_I is not checked because only whole words are issued.
  wire accept = HSEL_I && HTRANS_I[1] && HREADY_I;
  wire [7:0] addr_idx = HADDR_I[9:2];
  wire addr_high_zero = (HADDR_I[31:10] == 22'h000000);
  wire read_accept = accept && !HWRITE_I;
  wire read_err = read_accept && addr_high_zero
    && (addr_idx == rx_status_pkg::IDX_ERROR_WAKEUP_IRQ);

  logic dp_write;
  logic [7:0] dp_idx;
  logic dp_mapped;

  always_ff @(posedge SYS_CLK_I) begin
    if (!RST_N_I) begin
      dp_write <= 1'b0;
      dp_idx <= 8'h00;
      dp_mapped <= 1'b0;
    end else begin
      dp_write <= accept && HWRITE_I;
      dp_idx <= addr_idx;
      dp_mapped <= addr_high_zero;
    end
  end

  wire wr_ok = dp_write && dp_mapped;
  wire wr_mask = wr_ok && (dp_idx == rx_status_pkg::IDX_WAKEUP_MASK);
  wire wr_ctrl = wr_ok && (dp_idx == rx_status_pkg::IDX_STATUS_CONTROL);
  wire wr_deltas = wr_ok && (dp_idx == rx_status_pkg::IDX_WAKEUP_DELTAS);
  wire wr_cmd = wr_ok && (dp_idx == rx_status_pkg::IDX_COMMAND);
  wire set_default = wr_cmd && HWDATA_I[rx_status_pkg::CMD_SET_DEFAULT_BIT];
  wire clear_cmd = wr_cmd && HWDATA_I[rx_status_pkg::CMD_CLEAR_BIT];
  // Either command empties the FIFO-side registers.
  wire fifo_wipe = set_default || clear_cmd;

  // Software configuration.
  logic [7:0] wake_mask;
  logic wt_every_timeout;
  logic [2:0][7:0] wake_delta;

  always_ff @(posedge SYS_CLK_I) begin
    if (!RST_N_I || set_default) begin
      wake_mask <= rx_status_pkg::REG8_RESET;
      wt_every_timeout <= 1'b0;
      wake_delta <= '0;
    end else begin
      if (wr_mask) begin
        wake_mask <= HWDATA_I[7:0];
      end
      if (wr_ctrl) begin
        wt_every_timeout <= HWDATA_I[rx_status_pkg::CTRL_WT_EVERY_TIMEOUT_BIT];
      end
      if (wr_deltas) begin
        wake_delta <= HWDATA_I[23:0];
      end
    end
  end

  // Wake-up comparators, one per measurement channel.
  logic [2:0] wake_hit;
  genvar ch;
  generate
    for (ch = 0; ch < 3; ch++) begin : g_wake
      wire [7:0] meas = WAKE_MEAS_I.value[ch];
      wire [7:0] refv = WAKE_MEAS_I.reference[ch];
      wire [7:0] diff = (meas > refv) ? 8'(meas - refv) : 8'(refv - meas);
      assign wake_hit[ch] = WAKE_MEAS_I.valid[ch] && (diff > wake_delta[ch]);
    end
  endgenerate

  // Error and wake-up flags.
  logic [7:0] err_flags;
  wire [7:0] err_set = {
    RX_ERR_EVENTS_I.crc_error,
    RX_ERR_EVENTS_I.parity_error,
    RX_ERR_EVENTS_I.soft_framing,
    RX_ERR_EVENTS_I.hard_framing,
    RX_ERR_EVENTS_I.wakeup_timeout && wt_every_timeout,
    wake_hit
  };
  // A read clears only the flags it has seen; new events in the same cycle survive.
  wire [7:0] err_keep = read_err ? 8'h00 : err_flags;
  wire [7:0] next_err_flags = err_keep | err_set;

  always_ff @(posedge SYS_CLK_I) begin
    if (!RST_N_I || set_default) begin
      err_flags <= rx_status_pkg::REG8_RESET;
    end else begin
      err_flags <= next_err_flags;
    end
  end

  // The summary follows the flags, so it drops only after the read-clear.
  wire summary_next = |(next_err_flags & ~wake_mask) && !set_default;
  always_ff @(posedge SYS_CLK_I) begin
    if (!RST_N_I) begin
      ERR_SUMMARY_O <= 1'b0;
    end else begin
      ERR_SUMMARY_O <= summary_next;
    end
  end

  // FIFO byte count, limited to the documented range.
  logic [6:0] fifo_count;
  wire [6:0] count_limited = (FIFO_STATE_I.count > DEPTH_MAX) ? DEPTH_MAX : FIFO_STATE_I.count;
  wire fifo_empty = (FIFO_STATE_I.count == 7'h00);

  always_ff @(posedge SYS_CLK_I) begin
    if (!RST_N_I || fifo_wipe) begin
      fifo_count <= 7'h00;
    end else begin
      fifo_count <= count_limited;
    end
  end

  // FIFO last-byte status.
  logic fifo_underflow;
  logic fifo_overflow;
  logic last_incomplete;
  logic [2:0] last_byte_bit_count;
  logic missing_parity_flag;

  always_ff @(posedge SYS_CLK_I) begin
    if (!RST_N_I || fifo_wipe) begin
      fifo_underflow <= 1'b0;
      fifo_overflow <= 1'b0;
      last_incomplete <= 1'b0;
      last_byte_bit_count <= 3'h0;
      missing_parity_flag <= 1'b0;
    end else begin
      if (FIFO_STATE_I.host_read && fifo_empty) begin
        fifo_underflow <= 1'b1;
      end
      if (FIFO_STATE_I.overflow) begin
        fifo_overflow <= 1'b1;
      end
      if (FIFO_STATE_I.last_update) begin
        last_incomplete <= FIFO_STATE_I.last_incomplete;
        last_byte_bit_count <=
          FIFO_STATE_I.last_incomplete ? FIFO_STATE_I.last_bits : 3'h0;
        missing_parity_flag <= FIFO_STATE_I.missing_parity;
      end else if (fifo_empty) begin
        // Bit 2 of the count stays; only the bits named for an empty FIFO drop.
        last_incomplete <= 1'b0;
        last_byte_bit_count[1:0] <= 2'h0;
      end
    end
  end

  wire [7:0] fifo_status2 = {
    1'b0, fifo_underflow, fifo_overflow, last_incomplete, last_byte_bit_count, missing_parity_flag
  };

  // Collision position, kept from the first collision of an anticollision frame.
  logic [7:0] coll_pos;
  logic coll_seen;
  wire coll_take = COLLISION_I.event_hit && COLLISION_I.anticoll_frame && !coll_seen;
  wire [7:0] coll_value = {
    COLLISION_I.full_bytes,
    COLLISION_I.bits,
    COLLISION_I.on_parity
  };

  always_ff @(posedge SYS_CLK_I) begin
    if (!RST_N_I || fifo_wipe) begin
      coll_pos <= rx_status_pkg::REG8_RESET;
      coll_seen <= 1'b0;
    end else begin
      if (COLLISION_I.frame_start) begin
        coll_seen <= 1'b0;
      end else if (coll_take) begin
        coll_seen <= 1'b1;
      end
      if (coll_take) begin
        coll_pos <= coll_value;
      end
    end
  end

  // Read data is captured in the address phase so that it stands from flip-flops.
  wire [31:0] rd_mux =
    !addr_high_zero ? 32'h00000000 :
    (addr_idx == rx_status_pkg::IDX_ERROR_WAKEUP_IRQ) ? {24'h000000, err_flags} :
    (addr_idx == rx_status_pkg::IDX_FIFO_BYTE_COUNT) ? {25'h0000000, fifo_count} :
    (addr_idx == rx_status_pkg::IDX_FIFO_LAST_BYTE_STATUS) ? {24'h000000, fifo_status2} :
    (addr_idx == rx_status_pkg::IDX_COLLISION_POSITION) ? {24'h000000, coll_pos} :
    (addr_idx == rx_status_pkg::IDX_WAKEUP_MASK) ? {24'h000000, wake_mask} :
    (addr_idx == rx_status_pkg::IDX_STATUS_CONTROL) ? {30'h0, ERR_SUMMARY_O, wt_every_timeout} :
    (addr_idx == rx_status_pkg::IDX_WAKEUP_DELTAS) ? {8'h00, wake_delta} :
    32'h00000000;

  always_ff @(posedge SYS_CLK_I) begin
    if (!RST_N_I) begin
      HRDATA_O <= 32'h00000000;
    end else if (read_accept) begin
      HRDATA_O <= rd_mux;
    end
  end

  assign HREADYOUT_O = 1'b1;
  assign HRESP_O = 1'b0;

  // Checks.
  sequence s_read_err;
    read_err && !set_default;
  endsequence

  sequence s_quiet_set;
    err_set == 8'h00;
  endsequence

  property p_soft_framing;
    @(posedge SYS_CLK_I) disable iff (!RST_N_I)
      RX_ERR_EVENTS_I.soft_framing && !set_default
      |=> err_flags[rx_status_pkg::ERR_SOFT_FRAMING_BIT];
  endproperty
  a_soft_framing: assert property (p_soft_framing)
    else $error("Soft framing flag not set.");

  property p_hard_framing;
    @(posedge SYS_CLK_I) disable iff (!RST_N_I)
      RX_ERR_EVENTS_I.hard_framing && !set_default |=> err_flags[4];
  endproperty
  a_hard_framing: assert property (p_hard_framing)
    else $error("Hard framing flag not set.");

  property p_timer_gated;
    @(posedge SYS_CLK_I) disable iff (!RST_N_I)
      !err_flags[3] && !set_default && !(RX_ERR_EVENTS_I.wakeup_timeout && wt_every_timeout)
      |=> !err_flags[3];
  endproperty
  a_timer_gated: assert property (p_timer_gated)
    else $error("Wake-up timer flag set without option.");

  property p_phase_wake;
    @(posedge SYS_CLK_I) disable iff (!RST_N_I)
      wake_hit[rx_status_pkg::ERR_WAKE_PHASE_BIT] && !set_default |=> err_flags[1];
  endproperty
  a_phase_wake: assert property (p_phase_wake)
    else $error("Phase wake-up flag not set.");

  property p_read_clear;
    @(posedge SYS_CLK_I) disable iff (!RST_N_I)
      s_read_err ##0 s_quiet_set |=> err_flags == 8'h00;
  endproperty
  a_read_clear: assert property (p_read_clear)
    else $error("Error register not cleared by read.");

  property p_set_wins;
    @(posedge SYS_CLK_I) disable iff (!RST_N_I)
      s_read_err ##0 RX_ERR_EVENTS_I.crc_error
      |=> err_flags[7] && HRDATA_O[7:0] == $past(err_flags);
  endproperty
  a_set_wins: assert property (p_set_wins)
    else $error("Event lost during read-clear.");

  property p_commands;
    @(posedge SYS_CLK_I) disable iff (!RST_N_I)
      fifo_wipe |=> fifo_count == 7'h00 && fifo_status2 == 8'h00 && coll_pos == 8'h00;
  endproperty
  a_commands: assert property (p_commands)
    else $error("Clear command left status set.");

  property p_set_default;
    @(posedge SYS_CLK_I) disable iff (!RST_N_I)
      set_default |=> err_flags == 8'h00 && !ERR_SUMMARY_O && wake_mask == 8'h00;
  endproperty
  a_set_default: assert property (p_set_default)
    else $error("Set-default left error flags.");

  property p_count_range;
    @(posedge SYS_CLK_I) disable iff (!RST_N_I)
      fifo_count <= rx_status_pkg::FIFO_MAX_BYTES;
  endproperty
  a_count_range: assert property (p_count_range)
    else $error("FIFO count out of range.");

  property p_empty;
    @(posedge SYS_CLK_I) disable iff (!RST_N_I)
      fifo_empty && !FIFO_STATE_I.last_update
      |=> fifo_count == 7'h00 && !last_incomplete && last_byte_bit_count[1:0] == 2'h0;
  endproperty
  a_empty: assert property (p_empty)
    else $error("Empty FIFO shows last-byte bits.");

  property p_coll_outside;
    @(posedge SYS_CLK_I) disable iff (!RST_N_I)
      COLLISION_I.event_hit && !COLLISION_I.anticoll_frame && !fifo_wipe |=> $stable(coll_pos);
  endproperty
  a_coll_outside: assert property (p_coll_outside)
    else $error("Collision outside frame recorded.");

  property p_summary;
    @(posedge SYS_CLK_I) disable iff (!RST_N_I)
      |(err_flags & ~wake_mask) && !read_err && !set_default |=> ERR_SUMMARY_O;
  endproperty
  a_summary: assert property (p_summary)
    else $error("Summary not raised for unmasked flag.");

endmodule // rx_status_regs

`default_nettype wire

// file: test/ahb_host_model.sv
// Purpose: Host model that reaches the receive status registers over AHB-Lite.
// Assumes: One slave whose hreadyout is the bus hready; single word transfers.
// Notes: Outside a data phase the data lines show the inverse of the last word.
`timescale 1ns/1ps
`default_nettype none

module ahb_host_model (
  input wire logic clk_i,
  input wire logic hready_i,
  input wire logic [31:0] hrdata_i,
  output logic hsel_o,
  output logic [31:0] haddr_o,
  output logic [1:0] htrans_o,
  output logic hwrite_o,
  output logic [2:0] hsize_o,
  output logic [31:0] hwdata_o
);
  logic [7:0] saved_status = 8'h00;

  initial begin
    hsel_o = 1'b0;
    haddr_o = 32'h0;
    htrans_o = 2'b00;
    hwrite_o = 1'b0;
    hsize_o = 3'b010;
    hwdata_o = 32'h0;
  end

  // The caller enters just after a rising edge; every change lands by non-blocking assignment.
  task automatic xfer(input logic wr, input logic [7:0] idx, input logic [31:0] wd,
                      output logic [31:0] rd);
    hsel_o <= 1'b1;
    haddr_o <= {22'h0, idx, 2'b00};
    htrans_o <= 2'b10;
    hwrite_o <= wr;
    hsize_o <= 3'b010;
    @(posedge clk_i);
    while (hready_i !== 1'b1) @(posedge clk_i);
    hsel_o <= 1'b0;
    htrans_o <= 2'b00;
    hwdata_o <= wd;
    @(posedge clk_i);
    while (hready_i !== 1'b1) @(posedge clk_i);
    rd = hrdata_i;
    hwdata_o <= ~wd;
  endtask

  // Emptying the FIFO wipes the incomplete bit and bits 1:0 of the bit count, so a copy is kept while one is pending.
  task automatic fifo_status(output logic [31:0] cnt, output logic [31:0] st2);
    xfer(1'b0, rx_status_pkg::IDX_FIFO_BYTE_COUNT, 32'h0, cnt);
    xfer(1'b0, rx_status_pkg::IDX_FIFO_LAST_BYTE_STATUS, 32'h0, st2);
    if (st2[rx_status_pkg::FIFO_INCOMPLETE_BIT] === 1'b1) saved_status = st2[7:0];
  endtask
endmodule // ahb_host_model

`default_nettype wire

// file: test/tb_rx_error_fifo_status_regs.sv
// Purpose: Self-checking bench for the receive status register bank.
// Assumes: Event inputs are driven here on the bus clock; zero wait-state slave.
// Notes: Expected values follow the register layout and the package constants.
`timescale 1ns/1ps
`default_nettype none

module tb_rx_error_fifo_status_regs;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic hsel, hwrite, hreadyout, hresp, summary;
  logic [31:0] haddr, hwdata, hrdata, rd, cnt;
  logic [1:0] htrans;
  logic [2:0] hsize;
  rx_status_pkg::rx_err_events_s ev = '0;
  rx_status_pkg::wake_meas_s wm = '0;
  rx_status_pkg::fifo_state_s fs = '0;
  rx_status_pkg::collision_s col = '0;
  logic [7:0] idx_tab [5] = '{8'h19, 8'h1A, 8'h1B, 8'h1C, 8'h3F};
  int n_mismatch = 0;
  int n_checks = 0;
  int cyc = 0;

  always #5 clk = ~clk;

  ahb_host_model i_host (.clk_i(clk), .hready_i(hreadyout), .hrdata_i(hrdata), .hsel_o(hsel),
    .haddr_o(haddr), .htrans_o(htrans), .hwrite_o(hwrite), .hsize_o(hsize), .hwdata_o(hwdata));

  rx_status_regs i_dut (.SYS_CLK_I(clk), .RST_N_I(rst_n), .HSEL_I(hsel), .HADDR_I(haddr),
    .HTRANS_I(htrans), .HWRITE_I(hwrite), .HSIZE_I(hsize), .HWDATA_I(hwdata),
    .HREADY_I(hreadyout), .HRDATA_O(hrdata), .HREADYOUT_O(hreadyout), .HRESP_O(hresp),
    .RX_ERR_EVENTS_I(ev), .WAKE_MEAS_I(wm), .FIFO_STATE_I(fs), .COLLISION_I(col),
    .ERR_SUMMARY_O(summary));

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic rd_chk(input string what, input logic [7:0] idx, input logic [31:0] exp);
    logic [31:0] v;
    i_host.xfer(1'b0, idx, 32'h0, v);
    chk(what, exp, v);
  endtask

  task automatic wr(input logic [7:0] idx, input logic [31:0] d);
    logic [31:0] v;
    i_host.xfer(1'b1, idx, d, v);
  endtask

  // The extra edge lets a mask or flag change reach the registered summary first.
  task automatic chk_sum(input logic exp);
    @(posedge clk);
    #1;
    chk("summary", {31'h0, exp}, {31'h0, summary});
  endtask

  task automatic pulse_err(input logic [4:0] e);
    ev <= e;
    @(posedge clk);
    ev <= '0;
    @(posedge clk);
  endtask

  task wake(input int c, input logic [7:0] v);
    wm.valid <= 3'(1 << c);
    wm.value[c] <= v;
    wm.reference[c] <= 8'h40;
    @(posedge clk);
    wm.valid <= 3'h0;
    @(posedge clk);
  endtask

  task automatic coll(input rx_status_pkg::collision_s c);
    col <= c;
    @(posedge clk);
    col <= '0;
    @(posedge clk);
  endtask

  task automatic fifo_edge(input logic [1:0] sel);
    fs.host_read <= sel[0];
    fs.overflow <= sel[1];
    @(posedge clk);
    fs.host_read <= 1'b0;
    fs.overflow <= 1'b0;
    @(posedge clk);
  endtask

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      n_mismatch++;
      print_verdict();
    end
  end

  initial begin
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    foreach (idx_tab[i]) rd_chk("reset_value", idx_tab[i], 32'h0);
    foreach (idx_tab[i]) wr(idx_tab[i], 32'hFF);
    foreach (idx_tab[i]) rd_chk("read_only", idx_tab[i], 32'h0);
    for (int k = 1; k < 5; k++) begin
      pulse_err(5'(1 << k));
      chk_sum(1'b1);
      rd_chk("err_flag", rx_status_pkg::IDX_ERROR_WAKEUP_IRQ, 32'(1 << (k + 3)));
      rd_chk("err_clear", rx_status_pkg::IDX_ERROR_WAKEUP_IRQ, 32'h0);
      chk_sum(1'b0);
    end
    pulse_err(5'h01);
    rd_chk("timer_off", rx_status_pkg::IDX_ERROR_WAKEUP_IRQ, 32'h0);
    wr(rx_status_pkg::IDX_STATUS_CONTROL, 32'h1);
    rd_chk("control", rx_status_pkg::IDX_STATUS_CONTROL, 32'h1);
    pulse_err(5'h01);
    rd_chk("timer_on", rx_status_pkg::IDX_ERROR_WAKEUP_IRQ, 32'h08);
    wr(rx_status_pkg::IDX_WAKEUP_MASK, 32'hFF);
    pulse_err(5'h10);
    chk_sum(1'b0);
    wr(rx_status_pkg::IDX_WAKEUP_MASK, 32'h7F);
    chk_sum(1'b1);
    rd_chk("masked_flag", rx_status_pkg::IDX_ERROR_WAKEUP_IRQ, 32'h80);
    wr(rx_status_pkg::IDX_WAKEUP_DELTAS, 32'h101010);
    rd_chk("deltas", rx_status_pkg::IDX_WAKEUP_DELTAS, 32'h00101010);
    for (int c = 0; c < 3; c++) begin
      wake(c, 8'h50);
      rd_chk("wake_at_delta", rx_status_pkg::IDX_ERROR_WAKEUP_IRQ, 32'h0);
      wake(c, 8'h2F);
      rd_chk("wake_beyond", rx_status_pkg::IDX_ERROR_WAKEUP_IRQ, 32'(1 << c));
    end
    fork
      rd_chk("clear_race", rx_status_pkg::IDX_ERROR_WAKEUP_IRQ, 32'h0);
      pulse_err(5'h10);
    join
    rd_chk("race_kept", rx_status_pkg::IDX_ERROR_WAKEUP_IRQ, 32'h80);
    fs <= '{7'h60, 1'b0, 1'b0, 1'b1, 1'b1, 3'b101, 1'b1};
    repeat (2) @(posedge clk);
    fs.last_update <= 1'b0;
    repeat (2) @(posedge clk);
    i_host.fifo_status(cnt, rd);
    chk("fifo_count", 32'h60, cnt);
    chk("last_byte", 32'h1B, rd);
    fs.count <= 7'h00;
    repeat (2) @(posedge clk);
    i_host.fifo_status(cnt, rd);
    chk("empty_count", 32'h0, cnt);
    chk("empty_status", 32'h09, rd);
    chk("saved_status", 32'h1B, {24'h0, i_host.saved_status});
    fifo_edge(2'b01);
    fifo_edge(2'b10);
    rd_chk("under_over", rx_status_pkg::IDX_FIFO_LAST_BYTE_STATUS, 32'h69);
    coll('{1'b0, 1'b1, 1'b1, 4'h0, 3'h0, 1'b0});
    coll('{1'b1, 1'b1, 1'b0, 4'hA, 3'h3, 1'b1});
    coll('{1'b1, 1'b1, 1'b0, 4'h2, 3'h5, 1'b0});
    rd_chk("collision", rx_status_pkg::IDX_COLLISION_POSITION, 32'hA7);
    pulse_err(5'h02);
    wr(rx_status_pkg::IDX_COMMAND, 32'h2);
    for (int i = 1; i < 4; i++) rd_chk("clear_cmd", idx_tab[i], 32'h0);
    rd_chk("clear_keeps_err", rx_status_pkg::IDX_ERROR_WAKEUP_IRQ, 32'h10);
    coll('{1'b1, 1'b0, 1'b0, 4'h3, 3'h1, 1'b0});
    rd_chk("long_message", rx_status_pkg::IDX_COLLISION_POSITION, 32'h0);
    pulse_err(5'h10);
    wr(rx_status_pkg::IDX_COMMAND, 32'h1);
    rd_chk("set_default", rx_status_pkg::IDX_ERROR_WAKEUP_IRQ, 32'h0);
    rd_chk("mask_default", rx_status_pkg::IDX_WAKEUP_MASK, 32'h0);
    chk("response", 32'h0, {31'h0, hresp});
    print_verdict();
  end
endmodule // tb_rx_error_fifo_status_regs

`default_nettype wire
